// [hdl/pmt_timer.sv]
// Period match timer with prescaler, postscaler, interrupt logic and Wishbone slave
`timescale 1ns/1ps
module pmt_timer (
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    input  wire logic                     wb_cyc_i,
    input  wire logic                     wb_stb_i,
    input  wire logic                     wb_we_i,
    input  wire logic [pmt_pkg::ADDR_W+1:0] wb_adr_i,
    input  wire logic [31:0]              wb_dat_i,
    input  wire logic [3:0]               wb_sel_i,
    output logic      [31:0]              wb_dat_o,
    output logic                          wb_ack_o,
    output logic                          wb_err_o,
    output logic                          sync_serial_port_clk_o,
    output pmt_pkg::pmt_tbase_t           capture_compare_unit_tbase_o,
    output logic                          core_irq_o,
    output logic                          irq_o
);
    import pmt_pkg::*;

    logic [7:0]  count_r;
    logic [7:0]  period_r;
    pmt_ctrl_t   ctrl_r;
    logic [7:0]  irq_ctrl_r;
    logic [7:0]  flags_r;
    logic [7:0]  enables_r;
    logic [1:0]  status_r;
    logic [1:0]  mask_r;
    logic [1:0]  instr_div_r;
    logic [3:0]  pre_cnt_r;
    logic [3:0]  post_cnt_r;
    logic        match_r;
    logic        wr_count;
    logic        wr_ctrl;
    logic        bus_req;
    logic        lane0;
    logic        instr_tick;
    logic        tick;
    logic        match_now;
    logic        post_done;
    logic [3:0]  pre_last;
    logic [7:0]  reg_idx;
    logic [7:0]  wbyte;
    logic [7:0]  rd_byte;
    logic        mapped;

    // Register decode shared by read and write paths
    function automatic logic is_mapped(input logic [7:0] idx);
        return idx == IDX_IRQ_CTRL || idx == IDX_PERIPH_FLAGS || idx == IDX_TIMER_COUNT
            || idx == IDX_TIMER_CTRL || idx == IDX_PERIPH_ENA || idx == IDX_TIMER_PERIOD
            || idx == IDX_IRQ_STATUS || idx == IDX_IRQ_MASK;
    endfunction : is_mapped

    function automatic logic [3:0] pre_terminal(input logic [1:0] sel);
        logic [3:0] t;
        t = PRE_LAST_DIV16;
        if (sel == 2'h0) begin
            t = PRE_LAST_DIV1;
        end else if (sel == 2'h1) begin
            t = PRE_LAST_DIV4;
        end
        return t;
    endfunction : pre_terminal

    assign reg_idx   = wb_adr_i[ADDR_W+1:2];
    assign wbyte     = wb_dat_i[7:0];
    assign bus_req   = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign mapped    = is_mapped(reg_idx);
    assign lane0     = wb_sel_i[0];
    assign wr_count  = bus_req && mapped && wb_we_i && lane0 && reg_idx == IDX_TIMER_COUNT;
    assign wr_ctrl   = bus_req && mapped && wb_we_i && lane0 && reg_idx == IDX_TIMER_CTRL;

    // Instruction clock is the core clock divided by four
    assign instr_tick = instr_div_r == INSTR_DIV_LAST;
    assign pre_last   = pre_terminal(ctrl_r.prescale_select);
    assign tick       = ctrl_r.timer_on && instr_tick && pre_cnt_r == pre_last;
    assign match_now  = tick && count_r == period_r;
    assign post_done  = match_now && post_cnt_r == ctrl_r.postscale_select;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            instr_div_r <= 2'h0;
        end else begin
            instr_div_r <= instr_div_r + 2'h1;
        end
    end

    // Prescaler counts instruction cycles while the timer runs
    always_ff @(posedge clk_i) begin
        if (rst_i || wr_count || wr_ctrl) begin
            pre_cnt_r <= 4'h0;
        end else if (ctrl_r.timer_on && instr_tick) begin
            pre_cnt_r <= (pre_cnt_r == pre_last) ? 4'h0 : pre_cnt_r + 4'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_r <= RST_COUNT;
        end else if (wr_count) begin
            count_r <= wbyte;
        end else if (tick) begin
            count_r <= (count_r == period_r) ? 8'h00 : count_r + 8'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || wr_count || wr_ctrl) begin
            post_cnt_r <= 4'h0;
        end else if (match_now) begin
            post_cnt_r <= post_done ? 4'h0 : post_cnt_r + 4'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            match_r <= 1'b0;
        end else begin
            match_r <= match_now;
        end
    end

    // Control write never touches the count register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= pmt_ctrl_t'(RST_CTRL[6:0]);
        end else if (wr_ctrl) begin
            ctrl_r <= pmt_ctrl_t'(wbyte[6:0] & CTRL_WMASK[6:0]);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            period_r <= RST_PERIOD;
        end else if (bus_req && wb_we_i && lane0 && reg_idx == IDX_TIMER_PERIOD) begin
            period_r <= wbyte;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_ctrl_r <= RST_ZERO;
            enables_r  <= RST_ZERO;
            mask_r     <= 2'h0;
        end else if (bus_req && wb_we_i && lane0) begin
            if (reg_idx == IDX_IRQ_CTRL) begin
                irq_ctrl_r <= wbyte;
            end
            if (reg_idx == IDX_PERIPH_ENA) begin
                enables_r <= wbyte;
            end
            if (reg_idx == IDX_IRQ_MASK) begin
                mask_r <= wbyte[1:0];
            end
        end
    end

    // Flag register: hardware set wins over a software write of zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_r <= RST_ZERO;
        end else begin
            if (bus_req && wb_we_i && lane0 && reg_idx == IDX_PERIPH_FLAGS) begin
                flags_r <= wbyte;
            end
            if (post_done) begin
                flags_r[FLAG_MATCH_BIT] <= 1'b1;
            end
        end
    end

    // Sticky event status, cleared by writing one; set wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_r <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (bus_req && wb_we_i && lane0 && reg_idx == IDX_IRQ_STATUS && wbyte[i]) begin
                    status_r[i] <= 1'b0;
                end
            end
            if (match_now) begin
                status_r[STAT_MATCH_BIT] <= 1'b1;
            end
            if (post_done) begin
                status_r[STAT_POST_BIT] <= 1'b1;
            end
        end
    end

    always_comb begin
        rd_byte = 8'h00;
        unique case (reg_idx)
            IDX_IRQ_CTRL:     rd_byte = irq_ctrl_r;
            IDX_PERIPH_FLAGS: rd_byte = flags_r;
            IDX_TIMER_COUNT:  rd_byte = count_r;
            IDX_TIMER_CTRL:   rd_byte = {1'b0, ctrl_r};
            IDX_PERIPH_ENA:   rd_byte = enables_r;
            IDX_TIMER_PERIOD: rd_byte = period_r;
            IDX_IRQ_STATUS:   rd_byte = {6'h00, status_r};
            IDX_IRQ_MASK:     rd_byte = {6'h00, mask_r};
            default:          rd_byte = 8'h00;
        endcase
    end

    // One-cycle answer; unmapped addresses get err
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req && mapped;
            wb_err_o <= bus_req && !mapped;
            wb_dat_o <= (bus_req && !wb_we_i) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

    assign sync_serial_port_clk_o = match_r;
    assign capture_compare_unit_tbase_o = '{timer_count_value: count_r,
                                            match_pulse:       match_r,
                                            count_tick:        tick};
    assign core_irq_o = flags_r[FLAG_MATCH_BIT] && enables_r[FLAG_MATCH_BIT]
                      && irq_ctrl_r[PERIPHERAL_IRQ_ENABLE_BIT] && irq_ctrl_r[GIE_BIT];
    assign irq_o = |(status_r & mask_r);
endmodule : pmt_timer

// [hdl/pmt_pkg.sv]
// Package for the period match timer: register map, fields, resets and types
package pmt_pkg;
    localparam int         ADDR_W            = 8;
    // Register indices as printed; byte address is four times the index
    localparam logic [7:0] IDX_IRQ_CTRL      = 8'h0B;
    localparam logic [7:0] IDX_PERIPH_FLAGS  = 8'h0C;
    localparam logic [7:0] IDX_TIMER_COUNT   = 8'h11;
    localparam logic [7:0] IDX_TIMER_CTRL    = 8'h12;
    localparam logic [7:0] IDX_PERIPH_ENA    = 8'h8C;
    localparam logic [7:0] IDX_TIMER_PERIOD  = 8'h92;
    localparam logic [7:0] IDX_IRQ_STATUS    = 8'hA0;
    localparam logic [7:0] IDX_IRQ_MASK      = 8'hA1;

    localparam int         CTRL_PRE_LSB      = 0;
    localparam int         CTRL_ON_BIT       = 2;
    localparam int         CTRL_POST_LSB     = 3;
    localparam int         FLAG_MATCH_BIT    = 1;
    localparam int         GIE_BIT           = 7;
    localparam int         PERIPHERAL_IRQ_ENABLE_BIT          = 6;
    localparam int         STAT_MATCH_BIT    = 0;
    localparam int         STAT_POST_BIT     = 1;

    localparam logic [7:0] CTRL_WMASK        = 8'h7F;
    localparam logic [7:0] RST_COUNT         = 8'h00;
    localparam logic [7:0] RST_PERIOD        = 8'hFF;
    localparam logic [7:0] RST_CTRL          = 8'h00;
    localparam logic [7:0] RST_ZERO          = 8'h00;
    localparam logic [1:0] INSTR_DIV_LAST    = 2'h3;
    localparam logic [3:0] PRE_LAST_DIV1     = 4'h0;
    localparam logic [3:0] PRE_LAST_DIV4     = 4'h3;
    localparam logic [3:0] PRE_LAST_DIV16    = 4'hF;

    typedef struct packed {
        logic [3:0] postscale_select;
        logic       timer_on;
        logic [1:0] prescale_select;
    } pmt_ctrl_t;

    typedef struct packed {
        logic [7:0] timer_count_value;
        logic       match_pulse;
        logic       count_tick;
    } pmt_tbase_t;
endpackage : pmt_pkg

// [verification/pmt_timer_props.sv]
// Port checker for the period match timer
`timescale 1ns/1ps
module pmt_timer_props (
    input wire logic                  clk_i,
    input wire logic                  rst_i,
    input wire logic                  wb_cyc_i,
    input wire logic                  wb_stb_i,
    input wire logic                  wb_we_i,
    input wire logic [pmt_pkg::ADDR_W+1:0] wb_adr_i,
    input wire logic [31:0]           wb_dat_i,
    input wire logic [3:0]            wb_sel_i,
    input wire logic [31:0]           wb_dat_o,
    input wire logic                  wb_ack_o,
    input wire logic                  wb_err_o,
    input wire logic                  sync_serial_port_clk_o,
    input wire pmt_pkg::pmt_tbase_t   capture_compare_unit_tbase_o,
    input wire logic                  core_irq_o,
    input wire logic                  irq_o
);
    import pmt_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic       req;
    logic       wr_cnt;
    logic [7:0] cnt;
    logic       tick;
    assign req    = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign wr_cnt = req && wb_we_i && wb_sel_i[0] && wb_adr_i[9:2] == IDX_TIMER_COUNT;
    assign cnt    = capture_compare_unit_tbase_o.timer_count_value;
    assign tick   = capture_compare_unit_tbase_o.count_tick;
    a_ack_follows: assert property (req |=> wb_ack_o ^ wb_err_o)
        else $error("request not answered in one cycle");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_read_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    a_tick_space: assert property (tick |=> !tick [*3])
        else $error("ticks closer than four cycles");
    a_count_step: assert property (tick && !wr_cnt |=> cnt == $past(cnt) + 8'h01 || cnt == 8'h00)
        else $error("count did not step or wrap");
    a_count_hold: assert property (!tick && !wr_cnt |=> $stable(cnt))
        else $error("count moved without a tick");
    a_match_ssp: assert property (sync_serial_port_clk_o |-> $past(tick) && cnt == 8'h00)
        else $error("serial clock pulse without match");
    a_match_base: assert property (capture_compare_unit_tbase_o.match_pulse |-> sync_serial_port_clk_o)
        else $error("time base match differs from serial clock");
    a_reset_clear: assert property ($past(rst_i) |-> cnt == 8'h00 && !irq_o && !core_irq_o)
        else $error("state not cleared by reset");
endmodule : pmt_timer_props

bind pmt_timer pmt_timer_props i_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
    .sync_serial_port_clk_o(sync_serial_port_clk_o), .core_irq_o(core_irq_o), .irq_o(irq_o),
    .capture_compare_unit_tbase_o(capture_compare_unit_tbase_o));

// [verification/pmt_timer_test.sv]
// Self-checking bench for the period match timer
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_total++; $display("ERROR t=%0t got %0h exp %0h", $time, g, e); end end
module pmt_timer_test;
    import pmt_pkg::*;
    logic              clk_i = 1'b0;
    logic              rst_i = 1'b1;
    logic              wb_cyc_i = 1'b0;
    logic              wb_stb_i = 1'b0;
    logic              wb_we_i = 1'b0;
    logic [ADDR_W+1:0] wb_adr_i = '0;
    logic [31:0]       wb_dat_i = '0;
    logic [3:0]        wb_sel_i = 4'h0;
    logic [31:0]       wb_dat_o;
    logic              wb_ack_o, wb_err_o, ssp_clk, core_irq_o, irq_o, bad;
    pmt_tbase_t        tbase;
    logic [7:0]        rd, p;
    logic [3:0]        post;
    logic [7:0]        ridx [6] = '{IDX_TIMER_COUNT, IDX_TIMER_PERIOD, IDX_TIMER_CTRL,
                                    IDX_PERIPH_FLAGS, IDX_PERIPH_ENA, IDX_IRQ_CTRL};
    logic [7:0]        rexp [6] = '{RST_COUNT, RST_PERIOD, RST_CTRL, 8'h00, 8'h00, 8'h00};
    int                err_total = 0;
    int                total_checks = 0;
    pmt_timer i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .irq_o(irq_o),
        .sync_serial_port_clk_o(ssp_clk), .capture_compare_unit_tbase_o(tbase),
        .core_irq_o(core_irq_o));
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish
    // One classic cycle; called just after a rising edge
    task automatic bus(input logic we, input logic [7:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_sel_i <= 4'h1;
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= {24'h000000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_total++;
            tally_and_finish();
        end
        rd = wb_dat_o[7:0];
        bad = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : bus
    function automatic int exp_gap(input int c, input int pv);
        return 4 * (c == 0 ? 1 : c == 1 ? 4 : 16) * (pv + 1);
    endfunction : exp_gap
    // Counts raw matches and their spacing until the postscaled interrupt
    task automatic run_until_irq(input int gap, input int want);
        int n, last, np, stop;
        n = 0;
        last = 0;
        np = 0;
        stop = 0;
        while (stop < 2 && n < 20000) begin
            @(posedge clk_i);
            n++;
            if (ssp_clk === 1'b1) begin
                if (np > 0) `CHK(n - last, gap)
                np++;
                last = n;
            end
            if (irq_o === 1'b1 || stop > 0) stop++;
        end
        if (n >= 20000) begin
            err_total++;
            tally_and_finish();
        end
        `CHK(np, want)
    endtask : run_until_irq
    initial begin
        void'($urandom(69712));
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        foreach (ridx[i]) begin
            bus(1'b0, ridx[i], 8'h00);
            `CHK(rd, rexp[i])
        end
        bus(1'b0, 8'h40, 8'h00);
        `CHK(bad, 1'b1)
        bus(1'b1, IDX_TIMER_CTRL, 8'hFB);
        bus(1'b0, IDX_TIMER_CTRL, 8'h00);
        `CHK(rd, 8'h7B)
        bus(1'b1, IDX_TIMER_COUNT, 8'h5A);
        repeat (40) @(posedge clk_i);
        bus(1'b1, IDX_TIMER_CTRL, 8'h00);
        bus(1'b0, IDX_TIMER_COUNT, 8'h00);
        `CHK(rd, 8'h5A)
        for (int c = 0; c < 4; c++) begin
            p = 8'($urandom_range(4, 1));
            post = (c == 0) ? 4'h0 : (c == 3) ? 4'hF : 4'($urandom_range(15));
            bus(1'b1, IDX_TIMER_PERIOD, p);
            bus(1'b1, IDX_TIMER_COUNT, 8'h00);
            bus(1'b1, IDX_IRQ_MASK, 8'h02);
            bus(1'b1, IDX_PERIPH_ENA, 8'h02);
            bus(1'b1, IDX_IRQ_CTRL, 8'hC0);
            bus(1'b1, IDX_TIMER_CTRL, {1'b0, post, 1'b1, 2'(c)});
            run_until_irq(exp_gap(c, int'(p)), int'(post) + 1);
            bus(1'b0, IDX_PERIPH_FLAGS, 8'h00);
            `CHK(rd[FLAG_MATCH_BIT], 1'b1)
            `CHK(core_irq_o, 1'b1)
            `CHK(irq_o, 1'b1)
            bus(1'b1, IDX_TIMER_CTRL, 8'h00);
            bus(1'b1, IDX_IRQ_MASK, 8'h00);
            `CHK(irq_o, 1'b0)
            bus(1'b1, IDX_PERIPH_FLAGS, 8'h00);
            bus(1'b1, IDX_IRQ_STATUS, 8'h03);
            `CHK(core_irq_o, 1'b0)
        end
        tally_and_finish();
    end
endmodule : pmt_timer_test
